//--- common/link_mon_pkg.sv
// Constants, field layouts and types shared by the serial link error monitor.
package link_mon_pkg;

    // ----------------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------------
    localparam logic [11:0] A_LINK_CFG = 12'h300;
    localparam logic [11:0] A_SYNC_DUR = 12'h312;
    localparam logic [11:0] A_CGS      = 12'h470;
    localparam logic [11:0] A_FS       = 12'h471;
    localparam logic [11:0] A_CSUM     = 12'h472;
    localparam logic [11:0] A_ILAS     = 12'h473;
    localparam logic [11:0] A_QUAL     = 12'h476;
    localparam logic [11:0] A_THR      = 12'h47C;
    localparam logic [11:0] A_MASK     = 12'h47D;
    localparam logic [11:0] A_CTL      = 12'h480;
    localparam logic [11:0] A_HOLD     = 12'h488;
    localparam logic [11:0] A_TC       = 12'h490;
    localparam logic [11:0] A_IEN      = 12'h4B8;
    localparam logic [11:0] A_IEN_MM   = 12'h4B9;
    localparam logic [11:0] A_IST      = 12'h4BA;
    localparam logic [11:0] A_IST_MM   = 12'h4BB;
    localparam logic [11:0] A_CNT      = 12'h4C0;
    localparam int          CNT_STRIDE = 8;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int ERR_UEK       = 0;
    localparam int ERR_NIT       = 1;
    localparam int ERR_BDE       = 2;
    localparam int NUM_ERR       = 3;
    localparam int QUAL_BIT      = 4;
    localparam int CSUM_MODE_BIT = 6;
    localparam int ENA_LSB       = 3;
    localparam int DUR_LSB       = 4;
    localparam int ACTIVE_BIT    = 3;
    localparam int IRQ_CGS       = 0;
    localparam int IRQ_FS        = 1;
    localparam int IRQ_CSUM      = 2;
    localparam int IRQ_ILAS      = 3;
    localparam int IRQ_DESKEW    = 4;
    localparam int IRQ_THR_LSB   = 5;
    localparam int PARAM_BYTES   = 14;
    localparam int CSUM_BYTES    = 13;

    // ----------------------------------------------------------------------
    // Reset values and counter limits
    // ----------------------------------------------------------------------
    localparam logic [7:0] THR_RST    = 8'hFF;
    localparam logic [7:0] MASK_RST   = 8'h07;
    localparam logic [7:0] CTL_RST    = 8'h3F;
    localparam logic [7:0] IEN_MM_RST = 8'h01;
    localparam logic [7:0] ZERO_RST   = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_ZERO   = 8'h00;
    localparam logic [2:0] DISP_LIMIT = 3'h4;

    // ----------------------------------------------------------------------
    // Timing: resync length in frames and octets, pulse widths in cycles
    // ----------------------------------------------------------------------
    localparam int RESYNC_FRAMES  = 5;
    localparam int RESYNC_OCTETS  = 9;
    localparam int OCTETS_PER_CLK = 4;
    localparam logic [3:0] DUR_HALF_SEL = 4'h0;
    localparam logic [3:0] DUR_ONE_SEL  = 4'h1;
    localparam logic [7:0] DUR_HALF_CYC = 8'h01;
    localparam logic [7:0] DUR_ONE_CYC  = 8'h01;
    localparam logic [7:0] DUR_TWO_CYC  = 8'h02;

    // ----------------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------------
    typedef logic [7:0] octet_t;

    typedef struct packed {
        logic bad_disparity_error;
        logic not_in_table_error;
        logic unexpected_control_char;
    } err_vec_t;

    typedef struct packed {
        logic     char_valid;
        err_vec_t err;
    } lane_rx_t;

    typedef enum logic [1:0] {SYNC_IDLE, SYNC_PULSE, SYNC_RESYNC} sync_state_t;

endpackage : link_mon_pkg

//--- verilog/serial_link_error_monitor.sv
// Per-lane error counters, link status and sync request for the receiver.
// Contract
// - Disparity tally counts every bad-disparity character, in table or not.
// - Disparity error at a not-in-table position is dropped; later ones count.
// - Qualify bit makes not-in-table errors count toward the disparity tally.
// - Eight-bit counter per lane and type, each enabled by lane control bits.
// - Writing 0 to a counter's reset bit clears that counter.
// - Hold bit stops a counter at 0xFF; otherwise it wraps to 0x00.
// - One shared threshold register, reset 0xFF, serves all lanes and types.
// - Masked types reaching the threshold on any lane pull sync request low.
// - Lane status shows terminal count per type and lane active in bit 3.
// - Interrupt enables: threshold, link stage and mismatch bits.
// - Interrupt status bits sit at the positions of their enables.
// - Writing 1 to a status bit clears that interrupt.
// - Error pulse on sync request lasts one clock for the half or one setting, two otherwise.
// - Four bad-disparity characters reinitialize the link with a long resync.
// - Reinitialization clears all counters and leaves interrupt status alone.
// - Per-lane code group sync, frame sync and alignment status readable.
// - Checksum good when received byte equals low byte of selected sum.
// - Mismatch flag rises when configured and received parameters differ.
// - With qualify set, three not-in-table errors raise the disparity tally by three.
`timescale 1ns/1ps
module serial_link_error_monitor
    import link_mon_pkg::*;
#(
    parameter int NUM_LANES    = 8,
    parameter int FRAME_OCTETS = 1
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire octet_t      reg_wdata_i,
    input  wire lane_rx_t    lane_rx_i      [NUM_LANES],
    input  wire logic [NUM_LANES-1:0] lane_cgs_i,
    input  wire logic [NUM_LANES-1:0] lane_fs_i,
    input  wire logic [NUM_LANES-1:0] lane_ilas_i,
    input  wire logic [NUM_LANES-1:0] lane_active_i,
    input  wire logic        deskew_fail_i,
    input  wire octet_t      rx_checksum_i  [NUM_LANES],
    input  wire octet_t      field_sum_i    [NUM_LANES],
    input  wire octet_t      lane_id_i      [NUM_LANES],
    input  wire octet_t      rx_params_i    [PARAM_BYTES],
    input  wire octet_t      cfg_params_i   [PARAM_BYTES],
    output logic   [7:0]     reg_rdata_o,
    output logic             sync_request_out_n_o,
    output logic             link_reinit_o
);

    localparam int RESYNC_OCT = RESYNC_FRAMES * FRAME_OCTETS + RESYNC_OCTETS;
    localparam logic [7:0] RESYNC_CYC =
        8'((RESYNC_OCT + OCTETS_PER_CLK - 1) / OCTETS_PER_CLK);

    // ----------------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------------
    octet_t thr, next_thr, mask, next_mask, qual, next_qual;
    octet_t ien, next_ien, ien_mm, next_ien_mm;
    octet_t link_cfg, next_link_cfg, sync_dur, next_sync_dur;
    octet_t ctl [NUM_LANES], next_ctl [NUM_LANES];
    octet_t hold [NUM_LANES], next_hold [NUM_LANES];
    octet_t next_rdata;
    logic [NUM_ERR-1:0] ctl_clr [NUM_LANES];

    always_comb begin
        next_thr      = thr;
        next_mask     = mask;
        next_qual     = qual;
        next_ien      = ien;
        next_ien_mm   = ien_mm;
        next_link_cfg = link_cfg;
        next_sync_dur = sync_dur;
        next_ctl      = ctl;
        next_hold     = hold;
        ctl_clr       = '{default: '0};
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                A_THR:      next_thr      = reg_wdata_i;
                A_MASK:     next_mask     = reg_wdata_i;
                A_QUAL:     next_qual     = reg_wdata_i;
                A_IEN:      next_ien      = reg_wdata_i;
                A_IEN_MM:   next_ien_mm   = reg_wdata_i;
                A_LINK_CFG: next_link_cfg = reg_wdata_i;
                A_SYNC_DUR: next_sync_dur = reg_wdata_i;
                default: begin
                    for (int l = 0; l < NUM_LANES; l++) begin
                        if (reg_addr_i == A_CTL + 12'(l)) begin
                            next_ctl[l] = reg_wdata_i;
                            ctl_clr[l]  = ~reg_wdata_i[NUM_ERR-1:0];
                        end
                        if (reg_addr_i == A_HOLD + 12'(l))
                            next_hold[l] = reg_wdata_i;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            thr      <= THR_RST;
            mask     <= MASK_RST;
            qual     <= ZERO_RST;
            ien      <= ZERO_RST;
            ien_mm   <= IEN_MM_RST;
            link_cfg <= ZERO_RST;
            sync_dur <= ZERO_RST;
            ctl      <= '{default: CTL_RST};
            hold     <= '{default: ZERO_RST};
        end else begin
            thr      <= next_thr;
            mask     <= next_mask;
            qual     <= next_qual;
            ien      <= next_ien;
            ien_mm   <= next_ien_mm;
            link_cfg <= next_link_cfg;
            sync_dur <= next_sync_dur;
            ctl      <= next_ctl;
            hold     <= next_hold;
        end
    end

    // ----------------------------------------------------------------------
    // Error counters
    // ----------------------------------------------------------------------
    octet_t cnt [NUM_LANES][NUM_ERR], next_cnt [NUM_LANES][NUM_ERR];
    logic [NUM_ERR-1:0] tc [NUM_LANES], next_tc [NUM_LANES];
    logic [2:0] disp_cnt [NUM_LANES], next_disp_cnt [NUM_LANES];
    logic [NUM_ERR-1:0] ev [NUM_LANES];
    logic [NUM_LANES-1:0] disp_ev;
    logic [NUM_ERR-1:0] thr_hit;
    logic disp_limit, err_seen, do_reinit;

    always_comb begin
        next_cnt      = cnt;
        next_tc       = tc;
        next_disp_cnt = disp_cnt;
        thr_hit       = '0;
        disp_limit    = 1'b0;
        err_seen      = 1'b0;
        for (int l = 0; l < NUM_LANES; l++) begin
            ev[l] = lane_rx_i[l].err & {NUM_ERR{lane_rx_i[l].char_valid}};
            ev[l][ERR_BDE] = ev[l][ERR_BDE] & ~ev[l][ERR_NIT];
            ev[l] = ev[l] & ctl[l][ENA_LSB +: NUM_ERR];
            disp_ev[l] = lane_rx_i[l].char_valid
                & (lane_rx_i[l].err.bad_disparity_error
                | (qual[QUAL_BIT] & lane_rx_i[l].err.not_in_table_error));
            if (disp_ev[l]) begin
                next_disp_cnt[l] = disp_cnt[l] + 3'h1;
                disp_limit |= (next_disp_cnt[l] == DISP_LIMIT);
            end
            for (int t = 0; t < NUM_ERR; t++) begin
                if (ctl_clr[l][t]) begin
                    next_cnt[l][t] = CNT_ZERO;
                    next_tc[l][t]  = 1'b0;
                end else if (ev[l][t]) begin
                    err_seen = 1'b1;
                    if (!(hold[l][t] && cnt[l][t] == CNT_MAX))
                        next_cnt[l][t] = cnt[l][t] + 8'h01;
                    if (next_cnt[l][t] == thr) begin
                        next_tc[l][t] = 1'b1;
                        thr_hit[t]    = 1'b1;
                    end
                end
            end
        end
        do_reinit = disp_limit | (|(thr_hit & mask[NUM_ERR-1:0]));
        if (do_reinit) begin
            next_disp_cnt = '{default: '0};
            next_tc       = '{default: '0};
            next_cnt      = '{default: '{default: CNT_ZERO}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tc       <= '{default: '0};
            disp_cnt <= '{default: '0};
            cnt      <= '{default: '{default: CNT_ZERO}};
        end else begin
            cnt      <= next_cnt;
            tc       <= next_tc;
            disp_cnt <= next_disp_cnt;
        end
    end

    // ----------------------------------------------------------------------
    // Sync request generation
    // ----------------------------------------------------------------------
    sync_state_t state, next_state;
    octet_t timer, next_timer, dur_cyc;
    logic next_sync_n;

    always_comb begin
        unique case (sync_dur[DUR_LSB +: 4])
            DUR_HALF_SEL: dur_cyc = DUR_HALF_CYC;
            DUR_ONE_SEL:  dur_cyc = DUR_ONE_CYC;
            default:      dur_cyc = DUR_TWO_CYC;
        endcase
        next_state = state;
        next_timer = timer;
        if (do_reinit) begin
            next_state = SYNC_RESYNC;
            next_timer = RESYNC_CYC - 8'h01;
        end else if (err_seen && state == SYNC_IDLE) begin
            next_state = SYNC_PULSE;
            next_timer = dur_cyc - 8'h01;
        end else if (state != SYNC_IDLE) begin
            next_state = (timer == CNT_ZERO) ? SYNC_IDLE : state;
            next_timer = (timer == CNT_ZERO) ? timer : timer - 8'h01;
        end
        next_sync_n = (next_state == SYNC_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state                <= SYNC_IDLE;
            timer                <= CNT_ZERO;
            sync_request_out_n_o <= 1'b1;
            link_reinit_o        <= 1'b0;
        end else begin
            state                <= next_state;
            timer                <= next_timer;
            sync_request_out_n_o <= next_sync_n;
            link_reinit_o        <= do_reinit;
        end
    end

    // ----------------------------------------------------------------------
    // Link status and interrupt status
    // ----------------------------------------------------------------------
    logic [NUM_LANES-1:0] csum_ok, next_csum_ok;
    logic [NUM_LANES-1:0] prev_cgs, prev_fs, prev_ilas;
    logic mismatch, next_mismatch;
    octet_t ist, next_ist, ist_mm, next_ist_mm, ist_set, sum;

    always_comb begin
        for (int l = 0; l < NUM_LANES; l++) begin
            sum = lane_id_i[l];
            for (int b = 0; b < CSUM_BYTES; b++) begin
                sum = sum + rx_params_i[b];
            end
            sum = link_cfg[CSUM_MODE_BIT] ? sum : field_sum_i[l];
            next_csum_ok[l] = (rx_checksum_i[l] == sum);
        end
        next_mismatch = 1'b0;
        for (int b = 0; b < PARAM_BYTES; b++) begin
            next_mismatch |= (cfg_params_i[b] != rx_params_i[b]);
        end
        ist_set[IRQ_CGS]    = |(prev_cgs & ~lane_cgs_i);
        ist_set[IRQ_FS]     = |(prev_fs & ~lane_fs_i);
        ist_set[IRQ_CSUM]   = |(csum_ok & ~next_csum_ok);
        ist_set[IRQ_ILAS]   = |(prev_ilas & ~lane_ilas_i);
        ist_set[IRQ_DESKEW] = deskew_fail_i;
        ist_set[IRQ_THR_LSB +: NUM_ERR] = thr_hit;
        next_ist    = ist;
        next_ist_mm = ist_mm;
        if (reg_wr_i && reg_addr_i == A_IST)
            next_ist = ist & ~reg_wdata_i;
        if (reg_wr_i && reg_addr_i == A_IST_MM)
            next_ist_mm = ist_mm & ~reg_wdata_i;
        next_ist = next_ist | (ist_set & ien);
        next_ist_mm[0] = next_ist_mm[0]
            | (next_mismatch & ~mismatch & ien_mm[0]);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            csum_ok   <= '0;
            prev_cgs  <= '0;
            prev_fs   <= '0;
            prev_ilas <= '0;
            mismatch  <= 1'b0;
            ist       <= ZERO_RST;
            ist_mm    <= ZERO_RST;
        end else begin
            csum_ok   <= next_csum_ok;
            prev_cgs  <= lane_cgs_i;
            prev_fs   <= lane_fs_i;
            prev_ilas <= lane_ilas_i;
            mismatch  <= next_mismatch;
            ist       <= next_ist;
            ist_mm    <= next_ist_mm;
        end
    end

    // ----------------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------------
    always_comb begin
        next_rdata = ZERO_RST;
        unique case (reg_addr_i)
            A_CGS:      next_rdata = 8'(lane_cgs_i);
            A_FS:       next_rdata = 8'(lane_fs_i);
            A_CSUM:     next_rdata = 8'(csum_ok);
            A_ILAS:     next_rdata = 8'(lane_ilas_i);
            A_QUAL:     next_rdata = qual;
            A_THR:      next_rdata = thr;
            A_MASK:     next_rdata = mask;
            A_IEN:      next_rdata = ien;
            A_IEN_MM:   next_rdata = ien_mm;
            A_IST:      next_rdata = ist;
            A_IST_MM:   next_rdata = ist_mm;
            A_LINK_CFG: next_rdata = link_cfg;
            A_SYNC_DUR: next_rdata = sync_dur;
            default: begin
                for (int l = 0; l < NUM_LANES; l++) begin
                    if (reg_addr_i == A_CTL + 12'(l))
                        next_rdata = ctl[l];
                    if (reg_addr_i == A_HOLD + 12'(l))
                        next_rdata = hold[l];
                    if (reg_addr_i == A_TC + 12'(l)) begin
                        next_rdata = 8'(tc[l]);
                        next_rdata[ACTIVE_BIT] = lane_active_i[l];
                    end
                    for (int t = 0; t < NUM_ERR; t++) begin
                        if (reg_addr_i == A_CNT + 12'(t * CNT_STRIDE + l))
                            next_rdata = cnt[l][t];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= ZERO_RST;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence resync_start;
        link_reinit_o && !sync_request_out_n_o;
    endsequence

    sequence resync_loaded;
        state == SYNC_RESYNC && timer == RESYNC_CYC - 8'h01;
    endsequence

    chk_disp_reinit: assert property (
        disp_ev[0] && disp_cnt[0] == 3'h3 |=> resync_start and resync_loaded)
        else $error("four disparity errors did not reinitialize");

    chk_mask_sync: assert property (
        |(thr_hit & mask[NUM_ERR-1:0]) |=> resync_start)
        else $error("masked threshold hit did not request sync");

    chk_reinit_clear: assert property (
        do_reinit |=> cnt[0][ERR_BDE] == CNT_ZERO && tc[0] == '0
            && disp_cnt[0] == '0)
        else $error("reinitialization left a counter set");

    chk_hold_stop: assert property (
        ev[0][ERR_UEK] && hold[0][ERR_UEK] && cnt[0][ERR_UEK] == CNT_MAX
            && !ctl_clr[0][ERR_UEK] && !do_reinit
        |=> cnt[0][ERR_UEK] == CNT_MAX)
        else $error("held counter moved past terminal count");

    chk_wrap_zero: assert property (
        ev[0][ERR_UEK] && !hold[0][ERR_UEK] && cnt[0][ERR_UEK] == CNT_MAX
            && !ctl_clr[0][ERR_UEK] && !do_reinit
        |=> cnt[0][ERR_UEK] == CNT_ZERO)
        else $error("free counter did not wrap");

    chk_ctl_clear: assert property (
        reg_wr_i && reg_addr_i == A_CTL && !reg_wdata_i[ERR_NIT]
        |=> cnt[0][ERR_NIT] == CNT_ZERO)
        else $error("counter reset bit did not clear");

    chk_nit_mask: assert property (
        lane_rx_i[0].char_valid && lane_rx_i[0].err.not_in_table_error
            && !ctl_clr[0][ERR_BDE] && !do_reinit
        |=> $stable(cnt[0][ERR_BDE]))
        else $error("disparity counted at not-in-table position");

    chk_set_wins: assert property (
        reg_wr_i && reg_addr_i == A_IST && reg_wdata_i[IRQ_DESKEW]
            && deskew_fail_i && ien[IRQ_DESKEW]
        |=> ist[IRQ_DESKEW])
        else $error("clear beat a new interrupt event");

    chk_pulse_len: assert property (
        state == SYNC_IDLE && err_seen && !do_reinit
            && sync_dur[DUR_LSB +: 4] == DUR_ONE_SEL
        |=> !sync_request_out_n_o ##1 (sync_request_out_n_o || link_reinit_o))
        else $error("error pulse width wrong");

endmodule : serial_link_error_monitor

//--- tb/tx_partner.sv
// Behavioural transmitter feeding decoder flags and code group sync state.
`timescale 1ns/1ps
module tx_partner
    import link_mon_pkg::*;
(
    input  wire logic     sync_n_i,
    input  wire logic     lane_sel_i,
    input  wire err_vec_t err_i,
    output lane_rx_t      lane_rx_o [2],
    output logic [1:0]    lane_cgs_o
);
    // Every cycle carries a character; flags go to the picked lane only.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            lane_rx_o[i] = {1'b1, (lane_sel_i == i) ? err_i : 3'h0};
        end
    end
    // A held sync request sends both lanes back to code group sync.
    assign lane_cgs_o = sync_n_i ? 2'h3 : 2'h0;
endmodule : tx_partner

//--- tb/serial_link_error_monitor_tb.sv
// Self-checking bench for the serial link error monitor.
`timescale 1ns/1ps
module serial_link_error_monitor_tb import link_mon_pkg::*;;
    logic        clk_i = 0, rstn_i = 0, reg_wr_i = 0, sel = 0, dsk = 0;
    logic        sync_n, reinit;
    logic [11:0] reg_addr_i = 12'h000;
    octet_t      wd = 8'h00, rd, z [2], rx [PARAM_BYTES], cfg [PARAM_BYTES];
    err_vec_t    err = 3'h0;
    lane_rx_t    lrx [2];
    logic [1:0]  cgs, dn = 2'h3;
    int          error_cnt = 0, comparisons = 0, lo, ri;
    always #20 clk_i = ~clk_i;
    serial_link_error_monitor #(.NUM_LANES(2)) i_serial_link_error_monitor (
        .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(wd), .lane_rx_i(lrx),
        .lane_cgs_i(cgs), .lane_fs_i(dn), .lane_ilas_i(dn),
        .lane_active_i(dn), .deskew_fail_i(dsk), .rx_checksum_i(z),
        .field_sum_i(z), .lane_id_i(z), .rx_params_i(rx),
        .cfg_params_i(cfg), .reg_rdata_o(rd),
        .sync_request_out_n_o(sync_n), .link_reinit_o(reinit));
    tx_partner i_tx_partner (.sync_n_i(sync_n), .lane_sel_i(sel),
        .err_i(err), .lane_rx_o(lrx), .lane_cgs_o(cgs));
    task automatic chk(input octet_t s, input octet_t e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input octet_t d);
        @(negedge clk_i);
        reg_addr_i = a;
        wd = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rc(input logic [11:0] a, input octet_t e);
        @(negedge clk_i);
        reg_addr_i = a;
        @(negedge clk_i);
        chk(rd, e);
    endtask : rc
    // One flagged character, then sync low and reinit cycles are counted.
    task automatic inj(input logic l, input err_vec_t e);
        @(negedge clk_i);
        sel = l;
        err = e;
        @(negedge clk_i);
        err = 3'h0;
        lo = 0;
        ri = 0;
        repeat (9) begin
            lo += int'(sync_n === 1'b0);
            ri += int'(reinit === 1'b1);
            @(negedge clk_i);
        end
    endtask : inj
    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    initial begin
        #2000000;
        error_cnt++;
        close_out();
    end
    initial begin
        z = '{8'h00, 8'h00};
        foreach (rx[i]) begin
            rx[i] = 8'h00;
            cfg[i] = 8'h00;
        end
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
        rc(A_THR, THR_RST);
        rc(A_MASK, MASK_RST);
        rc(A_CTL, CTL_RST);
        rc(A_IEN_MM, IEN_MM_RST);
        rc(A_CGS, 8'h03);
        rc(A_FS, 8'h03);
        rc(A_ILAS, 8'h03);
        rc(A_CSUM, 8'h03);
        rc(12'h4FF, 8'h00);
        $display("Test reset values done");
        wr(A_IEN, 8'hF0);
        inj(1'b0, 3'h1);
        chk(8'(lo), 8'h01);
        wr(A_SYNC_DUR, 8'h20);
        inj(1'b1, 3'h2);
        chk(8'(lo), 8'h02);
        wr(A_SYNC_DUR, 8'h10);
        inj(1'b1, 3'h1);
        chk(8'(lo), 8'h01);
        wr(A_SYNC_DUR, 8'h00);
        wr(A_MASK, 8'h00);
        wr(A_THR, 8'h02);
        inj(1'b0, 3'h1);
        chk(8'(ri), 8'h00);
        rc(A_CNT, 8'h02);
        rc(A_TC, 8'h09);
        rc(A_IST, 8'h20);
        wr(A_CTL, 8'h3E);
        rc(A_CNT, 8'h00);
        wr(A_CTL, 8'h3F);
        $display("Test counters and threshold done");
        repeat (3) inj(1'b1, 3'h4);
        rc(12'h4D1, 8'h03);
        inj(1'b1, 3'h4);
        chk(8'(ri), 8'h01);
        chk(8'(lo), 8'h04);
        rc(12'h4D1, 8'h00);
        rc(A_IST, 8'hA0);
        wr(A_IST, 8'hA0);
        rc(A_IST, 8'h00);
        cfg[3] = 8'h01;
        rc(A_IST_MM, 8'h01);
        wr(A_IST_MM, 8'h01);
        rc(A_IST_MM, 8'h00);
        fork
            wr(A_IST, 8'h10);
            begin
                @(negedge clk_i);
                dsk = 1'b1;
                @(negedge clk_i);
                dsk = 1'b0;
            end
        join
        rc(A_IST, 8'h10);
        wr(A_IST, 8'h10);
        rc(A_IST, 8'h00);
        rx[0] = 8'h01;
        rc(A_CSUM, 8'h03);
        wr(A_LINK_CFG, 8'h40);
        rc(A_CSUM, 8'h00);
        $display("Test reinit and status done");
        wr(A_QUAL, 8'h10);
        repeat (4) inj(1'b0, 3'h2);
        chk(8'(ri), 8'h01);
        wr(A_QUAL, 8'h00);
        wr(A_HOLD, 8'h01);
        repeat (256) inj(1'b0, 3'h1);
        rc(A_CNT, 8'hFF);
        wr(A_HOLD, 8'h00);
        inj(1'b0, 3'h1);
        rc(A_CNT, 8'h00);
        inj(1'b0, 3'h6);
        rc(12'h4D0, 8'h00);
        rc(12'h4C8, 8'h01);
        wr(A_MASK, 8'h01);
        repeat (2) inj(1'b0, 3'h1);
        chk(8'(ri), 8'h01);
        chk(8'(lo), 8'h04);
        rc(A_CNT, 8'h00);
        $display("Test qualify, hold and masking done");
        close_out();
    end
endmodule : serial_link_error_monitor_tb
